// ### design/lsu_pkg.sv
// lsu_pkg: shared types and constants for the load/store instruction unit.
// assumes a single system clock; operations arrive already decoded.
package lsu_pkg;

  // ****************************************
  // operation codes
  // ****************************************
  typedef enum logic [4:0] {
    LSU_OP_IDLE_INSTRUCTION,
    LSU_OP_INDIRECT_LOAD,
    LSU_OP_INDIRECT_LOAD_INC,
    LSU_OP_INDIRECT_LOAD_DEC,
    LSU_OP_OFFSET_LOAD,
    LSU_OP_DIRECT_LOAD,
    LSU_OP_INDIRECT_WRITE,
    LSU_OP_INDIRECT_WRITE_INC,
    LSU_OP_INDIRECT_WRITE_DEC,
    LSU_OP_OFFSET_WRITE,
    LSU_OP_DIRECT_WRITE,
    LSU_OP_CODE_MEMORY_READ,
    LSU_OP_CODE_MEMORY_WRITE,
    LSU_OP_IO_IN,
    LSU_OP_IO_OUT,
    LSU_OP_PUSH,
    LSU_OP_POP,
    LSU_OP_SLEEP,
    LSU_OP_WATCHDOG_RESTART,
    LSU_OP_BREAK
  } lsu_op_t;

  // pointer pair selects
  localparam logic [1:0] LSU_PTR_FIRST = 2'h0;
  localparam logic [1:0] LSU_PTR_SECOND = 2'h1;
  localparam logic [1:0] LSU_PTR_THIRD = 2'h2;

  // register file indices
  localparam logic [4:0] LSU_REG_ZERO = 5'h00;
  localparam logic [4:0] LSU_REG_ONE = 5'h01;
  localparam logic [4:0] LSU_REG_PTR_BASE = 5'h1a;

  // cycle counts
  localparam int LSU_CYC_DATA = 2;
  localparam int LSU_CYC_CODE = 3;
  localparam int LSU_CYC_SINGLE = 1;

  // reset values
  localparam logic [7:0] LSU_REG_RST = 8'h00;
  localparam logic [15:0] LSU_SP_RST = 16'h08ff;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    lsu_op_t op;
    logic [4:0] reg_idx;
    logic [1:0] ptr_sel;
    logic [5:0] disp;
    logic [15:0] addr;
  } lsu_instr_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } lsu_mem_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } lsu_code_req_t;

endpackage

// ### design/lsu_regfile.sv
// lsu_regfile: 32 x 8 working registers with pointer-pair access.
// assumes one write port per cycle plus one 16-bit pointer write.
`timescale 1ns/100ps
`default_nettype none
module lsu_regfile
  import lsu_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // byte write port
  input wire logic we_i,
  input wire logic [4:0] widx_i,
  input wire logic [7:0] wdata_i,
  // pointer write port
  input wire logic pwe_i,
  input wire logic [1:0] psel_i,
  input wire logic [15:0] pdata_i,
  // read ports
  input wire logic [4:0] ridx_i,
  output logic [7:0] rdata_o,
  output logic [7:0] reg_zero_o,
  output logic [7:0] reg_one_o,
  output logic [15:0] ptr0_o,
  output logic [15:0] ptr1_o,
  output logic [15:0] ptr2_o
);

  logic [7:0] regs_r [32];

  // ****************************************
  // storage
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_reg
      localparam logic [4:0] IDX = 5'(gi);
      localparam logic [1:0] PAIR = 2'((gi - 26) / 2);
      // byte port wins over pointer update on same register
      always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          regs_r[gi] <= LSU_REG_RST;
        end else if (we_i && widx_i == IDX) begin
          regs_r[gi] <= wdata_i;
        end else if (gi >= 26 && pwe_i && psel_i == PAIR) begin
          regs_r[gi] <= (gi % 2 == 0) ? pdata_i[7:0] : pdata_i[15:8];
        end
      end
    end
  endgenerate

  // read muxes
  assign rdata_o = regs_r[ridx_i];
  assign reg_zero_o = regs_r[0];
  assign reg_one_o = regs_r[1];
  assign ptr0_o = {regs_r[27], regs_r[26]};
  assign ptr1_o = {regs_r[29], regs_r[28]};
  assign ptr2_o = {regs_r[31], regs_r[30]};

endmodule
`default_nettype wire

// ### design/lsu_cycle_counter.sv
// lsu_cycle_counter: counts the cycles of a multi-cycle operation.
// assumes start is only pulsed while idle.
`timescale 1ns/100ps
`default_nettype none
module lsu_cycle_counter (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic start_i,
  input wire logic [1:0] len_i,
  // status
  output logic busy_o,
  output logic last_o,
  output logic [1:0] step_o
);

  logic [1:0] step_r;
  logic [1:0] len_r;
  logic busy_r;

  // step advances each cycle until the length is reached
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      step_r <= 2'h0;
      len_r <= 2'h0;
      busy_r <= 1'b0;
    end else if (start_i) begin
      step_r <= 2'h1;
      len_r <= len_i;
      busy_r <= len_i > 2'h1;
    end else if (busy_r) begin
      step_r <= step_r + 2'h1;
      busy_r <= (step_r + 2'h1) < len_r;
    end else begin
      step_r <= 2'h0;
    end
  end

  assign busy_o = busy_r;
  assign last_o = busy_r && (step_r + 2'h1) == len_r;
  assign step_o = step_r;

endmodule
`default_nettype wire

// ### design/lsu_core.sv
// lsu_core: executes data-transfer and processor-control operations.
// assumes decoded operations, single-cycle memory answers, no status flags touched.
//
// Overview of operation
// - load pre-decrement via second/third pair: decrement, then read, 2 cycles.
// - offset load reads pointer plus displacement, pointer kept, 2 cycles.
// - load post-increment via third pair: read, then pointer plus one, 2 cycles.
// - direct load reads absolute address into register in 2 cycles.
// - store pre-decrement: decrement pointer, then write at new pointer, 2 cycles.
// - store post-increment: write at pointer, then pointer plus one, 2 cycles.
// - offset store writes at pointer plus displacement, pointer kept, 2 cycles.
// - direct store writes register at absolute address in 2 cycles.
// - code read fetches byte at third pointer, optional increment, 3 cycles.
// - I/O in and out move one register in one cycle.
// - push places source register on stack in 2 cycles.
// - pop takes stack top into destination register in 2 cycles.
// - sleep issues in one cycle and signals the sleep logic.
// - watchdog restart takes one cycle and pulses the watchdog.
// - break is only passed to debug logic, flags untouched.
`timescale 1ns/100ps
`default_nettype none
module lsu_core
  import lsu_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // instruction issue
  input wire logic instr_valid_i,
  input var lsu_instr_t instr_i,
  output logic instr_ready_o,
  output logic done_o,
  // data memory
  output lsu_mem_req_t dmem_o,
  input wire logic [7:0] dmem_rdata_i,
  // io space
  output lsu_mem_req_t io_o,
  input wire logic [7:0] io_rdata_i,
  // program memory
  output lsu_code_req_t code_o,
  input wire logic [7:0] code_rdata_i,
  input wire logic code_wr_done_i,
  // control strobes
  output logic sleep_o,
  output logic wdog_restart_o,
  output logic break_o,
  // observation
  output logic [15:0] sp_o,
  output logic [15:0] ptr_third_o
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {
    S_IDLE,
    S_EXEC,
    S_PROG
  } lsu_state_t;

  lsu_state_t state_r;
  lsu_instr_t cur_r;
  logic [15:0] sp_r;
  lsu_mem_req_t dmem_r;
  lsu_mem_req_t io_r;
  lsu_code_req_t code_r;
  logic sleep_r;
  logic wdog_r;
  logic break_r;
  logic done_r;

  logic [7:0] rdata;
  logic [7:0] reg_zero;
  logic [7:0] reg_one;
  logic [15:0] ptr0;
  logic [15:0] ptr1;
  logic [15:0] ptr2;
  logic [15:0] ptr_sel;
  logic rf_we;
  logic [4:0] rf_widx;
  logic [7:0] rf_wdata;
  logic rf_pwe;
  logic [15:0] rf_pdata;
  logic cnt_start;
  logic [1:0] cnt_len;
  logic cnt_busy;
  logic cnt_last;
  logic [1:0] cnt_step;
  logic issue;
  logic is_load;
  logic is_store;
  logic [15:0] eff_addr;

  // ****************************************
  // submodules
  // ****************************************
  lsu_regfile u_regfile (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .we_i(rf_we),
    .widx_i(rf_widx),
    .wdata_i(rf_wdata),
    .pwe_i(rf_pwe),
    .psel_i(cur_r.ptr_sel),
    .pdata_i(rf_pdata),
    .ridx_i(issue ? instr_i.reg_idx : cur_r.reg_idx),
    .rdata_o(rdata),
    .reg_zero_o(reg_zero),
    .reg_one_o(reg_one),
    .ptr0_o(ptr0),
    .ptr1_o(ptr1),
    .ptr2_o(ptr2)
  );

  lsu_cycle_counter u_counter (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(cnt_start),
    .len_i(cnt_len),
    .busy_o(cnt_busy),
    .last_o(cnt_last),
    .step_o(cnt_step)
  );

  // ****************************************
  // decode
  // ****************************************
  assign issue = instr_valid_i && instr_ready_o;
  assign instr_ready_o = (state_r == S_IDLE);

  // pointer of the issuing operation
  always_comb begin
    unique case (instr_i.ptr_sel)
      LSU_PTR_FIRST: ptr_sel = ptr0;
      LSU_PTR_SECOND: ptr_sel = ptr1;
      default: ptr_sel = ptr2;
    endcase
  end

  assign is_load = instr_i.op inside {LSU_OP_INDIRECT_LOAD, LSU_OP_INDIRECT_LOAD_INC,
                                      LSU_OP_INDIRECT_LOAD_DEC, LSU_OP_OFFSET_LOAD, LSU_OP_DIRECT_LOAD};
  assign is_store = instr_i.op inside {LSU_OP_INDIRECT_WRITE, LSU_OP_INDIRECT_WRITE_INC,
                                       LSU_OP_INDIRECT_WRITE_DEC, LSU_OP_OFFSET_WRITE, LSU_OP_DIRECT_WRITE};

  // effective data address of the issuing operation
  always_comb begin
    unique case (instr_i.op)
      LSU_OP_INDIRECT_LOAD_DEC, LSU_OP_INDIRECT_WRITE_DEC: eff_addr = ptr_sel - 16'h0001;
      LSU_OP_OFFSET_LOAD, LSU_OP_OFFSET_WRITE: eff_addr = ptr_sel + {10'h000, instr_i.disp};
      LSU_OP_DIRECT_LOAD, LSU_OP_DIRECT_WRITE: eff_addr = instr_i.addr;
      LSU_OP_PUSH: eff_addr = sp_r;
      LSU_OP_POP: eff_addr = sp_r + 16'h0001;
      default: eff_addr = ptr_sel;
    endcase
  end

  // cycle budget per operation
  always_comb begin
    cnt_start = 1'b0;
    cnt_len = 2'(LSU_CYC_SINGLE);
    if (issue) begin
      if (is_load || is_store || instr_i.op inside {LSU_OP_PUSH, LSU_OP_POP}) begin
        cnt_start = 1'b1;
        cnt_len = 2'(LSU_CYC_DATA);
      end else if (instr_i.op == LSU_OP_CODE_MEMORY_READ) begin
        cnt_start = 1'b1;
        cnt_len = 2'(LSU_CYC_CODE);
      end
    end
  end

  // ****************************************
  // sequencing
  // ****************************************
  // single-cycle ops never leave idle; code writes wait on the programmer
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= S_IDLE;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (cnt_start) begin
            state_r <= S_EXEC;
          end else if (issue && instr_i.op == LSU_OP_CODE_MEMORY_WRITE) begin
            state_r <= S_PROG;
          end
        end
        S_EXEC: begin
          if (cnt_last) begin
            state_r <= S_IDLE;
          end
        end
        S_PROG: begin
          if (code_wr_done_i) begin
            state_r <= S_IDLE;
          end
        end
      endcase
    end
  end

  // latch the operation being executed
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cur_r <= '0;
    end else if (issue) begin
      cur_r <= instr_i;
    end
  end

  // ****************************************
  // memory requests
  // ****************************************
  // requests issue on the first cycle; data returns for the second
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dmem_r <= '0;
    end else begin
      dmem_r.rd <= issue && (is_load || instr_i.op == LSU_OP_POP);
      dmem_r.wr <= issue && (is_store || instr_i.op == LSU_OP_PUSH);
      if (issue) begin
        dmem_r.addr <= eff_addr;
        dmem_r.wdata <= rdata;
      end
    end
  end

  // io out writes one cycle after issue; io in reads are driven combinationally at issue
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_r <= '0;
    end else begin
      io_r.rd <= 1'b0;
      io_r.wr <= issue && instr_i.op == LSU_OP_IO_OUT;
      if (issue) begin
        io_r.addr <= instr_i.addr;
        io_r.wdata <= rdata;
      end
    end
  end

  // code memory: read held for the fetch, write held until done
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      code_r <= '0;
    end else if (issue && instr_i.op == LSU_OP_CODE_MEMORY_READ) begin
      code_r.rd <= 1'b1;
      code_r.addr <= ptr2;
    end else if (issue && instr_i.op == LSU_OP_CODE_MEMORY_WRITE) begin
      code_r.wr <= 1'b1;
      code_r.addr <= ptr2;
      code_r.wdata <= {reg_one, reg_zero};
    end else if (state_r == S_PROG && code_wr_done_i) begin
      code_r.wr <= 1'b0;
    end else if (cnt_last) begin
      code_r.rd <= 1'b0;
    end
  end

  // ****************************************
  // register writeback
  // ****************************************
  // loads land on the final cycle; io in lands immediately
  always_comb begin
    rf_we = 1'b0;
    rf_widx = cur_r.reg_idx;
    rf_wdata = dmem_rdata_i;
    if (issue && instr_i.op == LSU_OP_IO_IN) begin
      rf_we = 1'b1;
      rf_widx = instr_i.reg_idx;
      rf_wdata = io_rdata_i;
    end else if (state_r == S_EXEC && cnt_last) begin
      if (cur_r.op inside {LSU_OP_INDIRECT_LOAD, LSU_OP_INDIRECT_LOAD_INC, LSU_OP_INDIRECT_LOAD_DEC,
                           LSU_OP_OFFSET_LOAD, LSU_OP_DIRECT_LOAD, LSU_OP_POP}) begin
        rf_we = 1'b1;
      end else if (cur_r.op == LSU_OP_CODE_MEMORY_READ) begin
        rf_we = 1'b1;
        rf_wdata = code_rdata_i;
      end
    end
  end

  // pointer update on final cycle; offset and plain forms leave it alone
  always_comb begin
    rf_pwe = 1'b0;
    rf_pdata = dmem_r.addr;
    if (state_r == S_EXEC && cnt_last) begin
      unique case (cur_r.op)
        LSU_OP_INDIRECT_LOAD_DEC, LSU_OP_INDIRECT_WRITE_DEC: rf_pwe = 1'b1;
        LSU_OP_INDIRECT_LOAD_INC, LSU_OP_INDIRECT_WRITE_INC: begin
          rf_pwe = 1'b1;
          rf_pdata = dmem_r.addr + 16'h0001;
        end
        LSU_OP_CODE_MEMORY_READ: begin
          rf_pwe = cur_r.ptr_sel == LSU_PTR_THIRD; // increment form only
          rf_pdata = code_r.addr + 16'h0001;
        end
        default: rf_pwe = 1'b0;
      endcase
    end
  end

  // ****************************************
  // stack pointer and strobes
  // ****************************************
  // push post-decrements, pop pre-increments
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sp_r <= LSU_SP_RST;
    end else if (issue && instr_i.op == LSU_OP_PUSH) begin
      sp_r <= sp_r - 16'h0001;
    end else if (issue && instr_i.op == LSU_OP_POP) begin
      sp_r <= sp_r + 16'h0001;
    end
  end

  // one-cycle control strobes; idle instruction touches nothing
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sleep_r <= 1'b0;
      wdog_r <= 1'b0;
      break_r <= 1'b0;
    end else begin
      sleep_r <= issue && instr_i.op == LSU_OP_SLEEP;
      wdog_r <= issue && instr_i.op == LSU_OP_WATCHDOG_RESTART;
      break_r <= issue && instr_i.op == LSU_OP_BREAK;
    end
  end

  // completion pulse one cycle after the last working cycle
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (issue && !cnt_start && instr_i.op != LSU_OP_CODE_MEMORY_WRITE)
                || (state_r == S_EXEC && cnt_last)
                || (state_r == S_PROG && code_wr_done_i);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign dmem_o = dmem_r;
  assign io_o = '{rd: issue && instr_i.op == LSU_OP_IO_IN, wr: io_r.wr, addr: issue ? instr_i.addr : io_r.addr,
                  wdata: io_r.wdata};
  assign code_o = code_r;
  assign sleep_o = sleep_r;
  assign wdog_restart_o = wdog_r;
  assign break_o = break_r;
  assign done_o = done_r;
  assign sp_o = sp_r;
  assign ptr_third_o = ptr2;

endmodule
`default_nettype wire

// ### testbench/lsu_core_monitor.sv
// lsu_core_monitor: port-level timing and address checks for lsu_core.
// assumes one clock domain and the active-high asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module lsu_core_monitor
  import lsu_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // issue side
  input wire logic instr_valid_i,
  input var lsu_instr_t instr_i,
  input wire logic instr_ready_o,
  input wire logic done_o,
  // far side
  input wire lsu_mem_req_t dmem_o,
  input wire lsu_mem_req_t io_o,
  input wire lsu_code_req_t code_o,
  input wire logic code_wr_done_i,
  // strobes and observation
  input wire logic sleep_o,
  input wire logic wdog_restart_o,
  input wire logic [15:0] sp_o,
  input wire logic [15:0] ptr_third_o
);
  // ****************
  // helpers
  // ****************
  // accepted request and its operation
  logic take;
  lsu_op_t op;
  logic third;
  assign take = instr_valid_i && instr_ready_o;
  assign op = instr_i.op;
  assign third = instr_i.ptr_sel == LSU_PTR_THIRD;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ****************
  // assertions
  // ****************
  a_data_done_time: assert property (take && op inside {[LSU_OP_INDIRECT_LOAD:LSU_OP_DIRECT_WRITE]} |-> ##2 done_o)
    else $error("data op done not two cycles after issue");
  a_single_done_time: assert property (take && op inside {LSU_OP_IO_IN, LSU_OP_IO_OUT} |=> done_o)
    else $error("single-cycle op done late");
  a_code_done_time: assert property (take && op == LSU_OP_CODE_MEMORY_READ |-> ##3 done_o)
    else $error("code read done not three cycles after issue");
  a_dec_addr: assert property (take && op == LSU_OP_INDIRECT_LOAD_DEC && third |->
    ##1 dmem_o.rd && dmem_o.addr == $past(ptr_third_o) - 16'h0001) else $error("pre-decrement address wrong");
  a_offset_addr: assert property (take && op inside {LSU_OP_OFFSET_LOAD, LSU_OP_OFFSET_WRITE} && third |->
    ##1 dmem_o.addr == $past(ptr_third_o) + $past(instr_i.disp) ##1 ptr_third_o == $past(ptr_third_o, 2))
    else $error("offset access address or pointer wrong");
  a_inc_ptr: assert property (take && op inside {LSU_OP_INDIRECT_LOAD_INC, LSU_OP_INDIRECT_WRITE_INC} && third |->
    ##1 dmem_o.addr == $past(ptr_third_o) ##1 ptr_third_o == $past(ptr_third_o, 2) + 16'h0001)
    else $error("post-increment address or pointer wrong");
  a_direct_addr: assert property (take && op inside {LSU_OP_DIRECT_LOAD, LSU_OP_DIRECT_WRITE} |->
    ##1 (dmem_o.rd ^ dmem_o.wr) && dmem_o.addr == $past(instr_i.addr)) else $error("direct access address wrong");
  a_io_in_now: assert property (take && op == LSU_OP_IO_IN |-> io_o.rd && io_o.addr == instr_i.addr)
    else $error("io read not at issue");
  a_push_sp: assert property (take && op == LSU_OP_PUSH |->
    ##1 dmem_o.wr && dmem_o.addr == $past(sp_o) ##1 sp_o == $past(sp_o, 2) - 16'h0001) else $error("push wrong");
  a_sleep_strobe: assert property (take && op == LSU_OP_SLEEP |=> sleep_o)
    else $error("sleep strobe missing");
  a_wdog_strobe: assert property (take && op == LSU_OP_WATCHDOG_RESTART |=> wdog_restart_o)
    else $error("watchdog strobe missing");
  a_code_wr_hold: assert property (code_o.wr && !code_wr_done_i |=> code_o.wr)
    else $error("code write dropped early");
  a_idle_quiet: assert property (take && op == LSU_OP_IDLE_INSTRUCTION |=>
    !dmem_o.wr && !io_o.wr ##1 ptr_third_o == $past(ptr_third_o, 2)) else $error("idle op changed state");
endmodule
bind lsu_core lsu_core_monitor u_mon (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
  .instr_i(instr_i), .instr_ready_o(instr_ready_o), .done_o(done_o), .dmem_o(dmem_o), .io_o(io_o),
  .code_o(code_o), .code_wr_done_i(code_wr_done_i), .sleep_o(sleep_o), .wdog_restart_o(wdog_restart_o),
  .sp_o(sp_o), .ptr_third_o(ptr_third_o));
`default_nettype wire

// ### testbench/lsu_far_model.sv
// lsu_far_model: data memory, io space and program memory facing lsu_core.
// assumes single-cycle data answers and a slow programmer for code writes.
`timescale 1ns/100ps
`default_nettype none
module lsu_far_model
  import lsu_pkg::*;
(
  input wire logic sys_clk_i,
  input wire lsu_mem_req_t dmem_i,
  output logic [7:0] dmem_rdata_o,
  input wire lsu_mem_req_t io_i,
  output logic [7:0] io_rdata_o,
  input wire lsu_code_req_t code_i,
  output logic [7:0] code_rdata_o,
  output logic code_wr_done_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r, io_last;
  logic [15:0] code_word, code_addr;
  int wait_cnt;
  // preload a known pattern
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h3c ^ i[7:0];
    end
    last_r = 8'h00;
    wait_cnt = 0;
    code_wr_done_o = 1'b0;
  end
  // unselected lines show inverted data so a stale sample is caught
  assign dmem_rdata_o = dmem_i.rd ? mem[dmem_i.addr] : ~last_r;
  assign io_rdata_o = io_i.rd ? io_i.addr[7:0] ^ 8'h5a : io_i.addr[7:0] ^ 8'ha5;
  assign code_rdata_o = code_i.rd ? code_i.addr[7:0] + 8'h11 : ~(code_i.addr[7:0] + 8'h11);
  // writes land on the edge; the programmer answers after three cycles
  always @(posedge sys_clk_i) begin
    code_wr_done_o <= 1'b0;
    if (dmem_i.rd) last_r <= mem[dmem_i.addr];
    if (dmem_i.wr) mem[dmem_i.addr] <= dmem_i.wdata;
    if (io_i.wr) io_last <= io_i.wdata;
    if (code_i.wr && !code_wr_done_o) begin
      wait_cnt <= (wait_cnt == 2) ? 0 : wait_cnt + 1;
      if (wait_cnt == 2) begin
        code_wr_done_o <= 1'b1;
        code_word <= code_i.wdata;
        code_addr <= code_i.addr;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/test_load_store_instruction_unit.sv
// test_load_store_instruction_unit: directed scenarios for lsu_core.
// assumes lsu_far_model on the far side and the bound port monitor.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_load_store_instruction_unit
  import lsu_pkg::*;
();
  logic sys_clk_i, sys_rst_i, instr_valid_i, instr_ready_o, done_o, code_wr_done, sleep_o, wdog_restart_o, break_o;
  lsu_instr_t instr_i;
  lsu_mem_req_t dmem_o, io_o;
  lsu_code_req_t code_o;
  logic [7:0] dmem_rdata, io_rdata, code_rdata;
  logic [15:0] sp_o, ptr_third_o;
  logic [2:0] seen;
  int checked = 0;
  int miscompares = 0;
  lsu_core u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .instr_ready_o(instr_ready_o), .done_o(done_o), .dmem_o(dmem_o), .dmem_rdata_i(dmem_rdata), .io_o(io_o),
    .io_rdata_i(io_rdata), .code_o(code_o), .code_rdata_i(code_rdata), .code_wr_done_i(code_wr_done),
    .sleep_o(sleep_o), .wdog_restart_o(wdog_restart_o), .break_o(break_o), .sp_o(sp_o), .ptr_third_o(ptr_third_o));
  lsu_far_model u_mem (.sys_clk_i(sys_clk_i), .dmem_i(dmem_o), .dmem_rdata_o(dmem_rdata), .io_i(io_o),
    .io_rdata_o(io_rdata), .code_i(code_o), .code_rdata_o(code_rdata), .code_wr_done_o(code_wr_done));
  // ****************
  // clock and closing
  // ****************
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // issue one op; cyc 0 skips the count, below 0 waits three cycles
  task automatic issue(input lsu_op_t op, input logic [4:0] r, input logic [1:0] p, input logic [15:0] a,
    input int cyc);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (instr_ready_o !== 1'b1 && n < 20);
    `CHK("ready", 1'b1, instr_ready_o)
    if (instr_ready_o !== 1'b1) print_verdict();
    instr_i = '{op: op, reg_idx: r, ptr_sel: p, disp: a[5:0], addr: a};
    instr_valid_i = 1'b1;
    @(posedge sys_clk_i);
    n = 0;
    seen = 3'b000;
    do begin
      @(negedge sys_clk_i);
      instr_valid_i = 1'b0;
      n++;
      seen = seen | {sleep_o, wdog_restart_o, break_o};
    end while (n < 12 && (cyc < 0 ? n < 3 : done_o !== 1'b1));
    if (cyc >= 0 && done_o !== 1'b1) begin
      miscompares++;
      $display("[ERR] done exp 1 got %b", done_o);
      print_verdict();
    end
    if (cyc > 0) `CHK("cycles", cyc, n)
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic test_direct();
    logic [15:0] z;
    z = {u_mem.mem[16'h0004], u_mem.mem[16'h0123]};
    issue(LSU_OP_DIRECT_LOAD, 5'h1e, LSU_PTR_FIRST, 16'h0123, LSU_CYC_DATA);
    issue(LSU_OP_DIRECT_LOAD, 5'h1f, LSU_PTR_FIRST, 16'h0004, LSU_CYC_DATA);
    `CHK("ptr_third", z, ptr_third_o)
    issue(LSU_OP_DIRECT_WRITE, 5'h1e, LSU_PTR_FIRST, 16'h0500, LSU_CYC_DATA);
    `CHK("mem_0500", z[7:0], u_mem.mem[16'h0500])
    $display("test_direct done");
  endtask
  // every pointer form through the third pair, loads then stores
  task automatic test_third();
    lsu_op_t ops [8] = '{LSU_OP_INDIRECT_LOAD, LSU_OP_INDIRECT_LOAD_INC, LSU_OP_INDIRECT_LOAD_DEC,
      LSU_OP_OFFSET_LOAD, LSU_OP_INDIRECT_WRITE, LSU_OP_INDIRECT_WRITE_INC, LSU_OP_INDIRECT_WRITE_DEC,
      LSU_OP_OFFSET_WRITE};
    int dlt [8] = '{0, 1, -1, 0, 0, 1, -1, 0};
    logic [15:0] z, ea;
    logic [7:0] v5, pre;
    v5 = u_mem.mem[16'h0010];
    issue(LSU_OP_DIRECT_LOAD, 5'h05, LSU_PTR_FIRST, 16'h0010, LSU_CYC_DATA);
    for (int i = 0; i < 8; i++) begin
      z = ptr_third_o;
      ea = z + ((i % 4 == 3) ? 16'h002a : (dlt[i] < 0 ? 16'hffff : 16'h0000));
      pre = u_mem.mem[ea];
      issue(ops[i], (i < 4) ? 5'h06 : 5'h05, LSU_PTR_THIRD, 16'h002a, LSU_CYC_DATA);
      `CHK("ptr_third", z + 16'(dlt[i]), ptr_third_o)
      if (i < 4) begin
        issue(LSU_OP_DIRECT_WRITE, 5'h06, LSU_PTR_FIRST, 16'h0600, LSU_CYC_DATA);
        `CHK("load_data", pre, u_mem.mem[16'h0600])
      end else begin
        `CHK("store_data", v5, u_mem.mem[ea])
      end
    end
    $display("test_third done");
  endtask
  task automatic test_code();
    logic [15:0] z;
    logic [7:0] v1;
    z = ptr_third_o;
    v1 = u_mem.mem[16'h0020];
    issue(LSU_OP_CODE_MEMORY_READ, LSU_REG_ZERO, LSU_PTR_FIRST, 16'h0000, LSU_CYC_CODE);
    `CHK("ptr_third", z, ptr_third_o)
    issue(LSU_OP_CODE_MEMORY_READ, 5'h09, LSU_PTR_THIRD, 16'h0000, LSU_CYC_CODE);
    `CHK("ptr_third", z + 16'h0001, ptr_third_o)
    issue(LSU_OP_DIRECT_WRITE, 5'h09, LSU_PTR_FIRST, 16'h0700, LSU_CYC_DATA);
    `CHK("code_byte", z[7:0] + 8'h11, u_mem.mem[16'h0700])
    issue(LSU_OP_DIRECT_LOAD, LSU_REG_ONE, LSU_PTR_FIRST, 16'h0020, LSU_CYC_DATA);
    issue(LSU_OP_CODE_MEMORY_WRITE, LSU_REG_ZERO, LSU_PTR_FIRST, 16'h0000, 0);
    `CHK("code_word", {v1, z[7:0] + 8'h11}, u_mem.code_word)
    `CHK("code_addr", z + 16'h0001, u_mem.code_addr)
    $display("test_code done");
  endtask
  task automatic test_io_stack();
    logic [15:0] s;
    issue(LSU_OP_IO_IN, 5'h07, LSU_PTR_FIRST, 16'h003d, LSU_CYC_SINGLE);
    issue(LSU_OP_IO_OUT, 5'h07, LSU_PTR_FIRST, 16'h0011, LSU_CYC_SINGLE);
    s = sp_o;
    issue(LSU_OP_PUSH, 5'h07, LSU_PTR_FIRST, 16'h0000, LSU_CYC_DATA);
    `CHK("io_out", 8'h3d ^ 8'h5a, u_mem.io_last)
    `CHK("stack_top", 8'h3d ^ 8'h5a, u_mem.mem[s])
    issue(LSU_OP_POP, 5'h08, LSU_PTR_FIRST, 16'h0000, LSU_CYC_DATA);
    `CHK("sp", s, sp_o)
    issue(LSU_OP_DIRECT_WRITE, 5'h08, LSU_PTR_FIRST, 16'h0800, LSU_CYC_DATA);
    `CHK("pop_data", 8'h3d ^ 8'h5a, u_mem.mem[16'h0800])
    $display("test_io_stack done");
  endtask
  task automatic test_ctrl();
    logic [15:0] z;
    z = ptr_third_o;
    issue(LSU_OP_IDLE_INSTRUCTION, 5'h00, LSU_PTR_FIRST, 16'h0000, LSU_CYC_SINGLE);
    `CHK("idle_strobes", 3'b000, seen)
    issue(LSU_OP_SLEEP, 5'h00, LSU_PTR_FIRST, 16'h0000, LSU_CYC_SINGLE);
    `CHK("sleep_strobe", 3'b100, seen)
    issue(LSU_OP_WATCHDOG_RESTART, 5'h00, LSU_PTR_FIRST, 16'h0000, LSU_CYC_SINGLE);
    `CHK("wdog_strobe", 3'b010, seen)
    issue(LSU_OP_BREAK, 5'h00, LSU_PTR_FIRST, 16'h0000, -1);
    `CHK("break_strobe", 3'b001, seen)
    `CHK("ptr_third", z, ptr_third_o)
    $display("test_ctrl done");
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    sys_rst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = '0;
    repeat (4) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    @(negedge sys_clk_i);
    test_direct();
    test_third();
    test_code();
    test_io_stack();
    test_ctrl();
    print_verdict();
  end
endmodule
`default_nettype wire
